/* rtl/tpec_counter.sv */
// Two-phase event counter channel with reload and interrupt request
`timescale 1ns/1ps

// How it works
// - Both pins take the two-phase pulse pair; besides register writes, only their edges move the count.
// - Phase order of the two pins picks up or down counting.
// - On overflow or underflow the reload value is loaded and counting goes on.
// - Up ratio is 1/(FFFF-n+1), down ratio is 1/(n+1) for reload n.
// - Counting starts while the start flag is one.
// - Counting halts while the start flag is zero.
// - Each overflow or underflow raises a one-cycle interrupt request.
// - Reading the timer register returns the current count.
// - A write while stopped loads both reload register and counter.
// - A write while running loads only the reload register.
// - A value written while running reaches the counter at the next reload.
// - Free-run mode wraps on overflow or underflow without reloading.
// - Normal mode: A rising counts up, A falling counts down, when B high.
// - Times-four mode counts every edge that occurs on one pin alone, direction by phase.
module tpec_counter (
	input  wire logic               CLK,
	input  wire logic               RST_B,
	input  wire logic               PHASE_A_INPUT_PIN,
	input  wire logic               PHASE_B_PIN,
	input  wire logic               START_FLAG,
	input  wire logic               FREE_RUN,
	input  wire tpec_pkg::tpec_mode_t MODE,
	input  wire logic               TMR_WE,
	input  wire logic [15:0]        TMR_WDATA,
	output logic [15:0]             TMR_RDATA,
	output logic [15:0]             RELOAD_VALUE,
	output logic                    IRQ
);
	import tpec_pkg::*;

	tpec_edge_if edges ();

	logic [15:0] count;
	logic [15:0] reload;
	logic        irq;
	logic [15:0] next_count;
	logic [15:0] next_reload;

	// Pin samplers
	tpec_sync #(
		.IDX (TPEC_PIN_A)
	) u_sync_a (
		.clk   (CLK),
		.rst_b (RST_B),
		.pin   (PHASE_A_INPUT_PIN),
		.edges (edges.src)
	);

	tpec_sync #(
		.IDX (TPEC_PIN_B)
	) u_sync_b (
		.clk   (CLK),
		.rst_b (RST_B),
		.pin   (PHASE_B_PIN),
		.edges (edges.src)
	);

	// Synchronised levels and edges
	wire a_lvl  = edges.lvl[TPEC_PIN_A];
	wire b_lvl  = edges.lvl[TPEC_PIN_B];
	wire a_rise = edges.rise[TPEC_PIN_A];
	wire a_fall = edges.fall[TPEC_PIN_A];
	wire b_rise = edges.rise[TPEC_PIN_B];
	wire b_fall = edges.fall[TPEC_PIN_B];
	wire a_edge = a_rise | a_fall;
	wire b_edge = b_rise | b_fall;

	// Start flag gates counting
	wire running = START_FLAG;

	// Normal mode: only pin A edges count while pin B is high
	wire norm_up = a_rise & b_lvl;
	wire norm_dn = a_fall & b_lvl;

	// Times-four: one edge at a time, direction from phase
	wire x4_single = a_edge ^ b_edge;
	wire x4_up_raw = (a_rise & b_lvl) | (a_fall & ~b_lvl)
		| (b_rise & ~a_lvl) | (b_fall & a_lvl);
	wire x4_dn_raw = (a_rise & ~b_lvl) | (a_fall & b_lvl)
		| (b_rise & a_lvl) | (b_fall & ~a_lvl);
	wire x4_up = x4_single & x4_up_raw;
	wire x4_dn = x4_single & x4_dn_raw;

	// Direction comes from the pulses, not from software
	wire is_x4   = (MODE == TPEC_X4);
	wire step_up = running & (is_x4 ? x4_up : norm_up);
	wire step_dn = running & (is_x4 ? x4_dn : norm_dn);

	// Overflow and underflow detection
	wire at_max   = (count == TPEC_CNT_MAX);
	wire at_min   = (count == TPEC_CNT_MIN);
	wire overflow = step_up & at_max;
	wire underflw = step_dn & at_min;
	wire wrap     = overflow | underflw;

	// Wrapped value for free-run mode
	wire [15:0] free_val = overflow ? TPEC_CNT_MIN : TPEC_CNT_MAX;

	// Reload register always takes a write
	assign next_reload = TMR_WE ? TMR_WDATA : reload;

	// Stopped write goes to the counter too
	wire load_direct = TMR_WE & ~running;

	wire [15:0] count_inc = 16'(count + TPEC_STEP);
	wire [15:0] count_dec = 16'(count - TPEC_STEP);

	always_comb begin
		next_count = count;
		if (load_direct) begin
			next_count = TMR_WDATA;
		end else if (wrap && FREE_RUN) begin
			next_count = free_val;
		end else if (wrap) begin
			next_count = next_reload;
		end else if (step_up) begin
			next_count = count_inc;
		end else if (step_dn) begin
			next_count = count_dec;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			count  <= TPEC_COUNT_RST;
			reload <= TPEC_RELOAD_RST;
			irq    <= 1'b0;
		end else begin
			count  <= next_count;
			reload <= next_reload;
			irq    <= wrap;
		end
	end

	// Register read returns the live count
	assign TMR_RDATA    = count;
	assign RELOAD_VALUE = reload;
	assign IRQ          = irq;

	// Checks

	property p_stop_hold;
		@(posedge CLK) disable iff (!RST_B)
		(!running && !TMR_WE) |=> (count == $past(count));
	endproperty
	a_stop_hold: assert property (p_stop_hold)
		else $error("Count moved while stopped");

	property p_write_stopped;
		@(posedge CLK) disable iff (!RST_B)
		(!running && TMR_WE)
			|=> (count == $past(TMR_WDATA))
			&& (reload == $past(TMR_WDATA));
	endproperty
	a_write_stopped: assert property (p_write_stopped)
		else $error("Stopped write did not load counter and reload");

	property p_write_running;
		@(posedge CLK) disable iff (!RST_B)
		(running && TMR_WE && !step_up && !step_dn)
			|=> (count == $past(count))
			&& (reload == $past(TMR_WDATA));
	endproperty
	a_write_running: assert property (p_write_running)
		else $error("Running write disturbed the counter");

	property p_overflow_reload;
		@(posedge CLK) disable iff (!RST_B)
		(step_up && at_max && !FREE_RUN && !TMR_WE)
			|=> (count == $past(reload)) && irq;
	endproperty
	a_overflow_reload: assert property (p_overflow_reload)
		else $error("Overflow did not reload");

	property p_underflow_reload;
		@(posedge CLK) disable iff (!RST_B)
		(step_dn && at_min && !FREE_RUN)
			|=> (count == $past(next_reload)) && irq;
	endproperty
	a_underflow_reload: assert property (p_underflow_reload)
		else $error("Underflow did not load the pending reload value");

	property p_free_wrap;
		@(posedge CLK) disable iff (!RST_B)
		(step_up && at_max && FREE_RUN)
			|=> (count == TPEC_CNT_MIN) && irq;
	endproperty
	a_free_wrap: assert property (p_free_wrap)
		else $error("Free-run overflow did not wrap to zero");

	property p_irq_cause;
		@(posedge CLK) disable iff (!RST_B)
		irq |-> $past(running) && (($past(count) == TPEC_CNT_MAX)
			|| ($past(count) == TPEC_CNT_MIN));
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("Interrupt request without overflow or underflow");

	property p_irq_pulse;
		@(posedge CLK) disable iff (!RST_B)
		!wrap |=> !irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("Interrupt request not a single-cycle pulse");

	property p_normal_b_low;
		@(posedge CLK) disable iff (!RST_B)
		(!is_x4 && !b_lvl && !TMR_WE) |=> (count == $past(count));
	endproperty
	a_normal_b_low: assert property (p_normal_b_low)
		else $error("Normal mode counted while pin B low");

	property p_normal_up;
		@(posedge CLK) disable iff (!RST_B)
		(running && !is_x4 && a_rise && b_lvl && !at_max && !TMR_WE)
			|=> (count == 16'($past(count) + TPEC_STEP));
	endproperty
	a_normal_up: assert property (p_normal_up)
		else $error("Normal mode rising edge did not count up");

	property p_x4_b_edge;
		@(posedge CLK) disable iff (!RST_B)
		(running && is_x4 && b_fall && !a_edge && a_lvl && !at_max
			&& !TMR_WE)
			|=> (count == 16'($past(count) + TPEC_STEP));
	endproperty
	a_x4_b_edge: assert property (p_x4_b_edge)
		else $error("Times-four mode missed a pin B edge");

	property p_x4_down;
		@(posedge CLK) disable iff (!RST_B)
		(running && is_x4 && a_rise && !b_edge && !b_lvl && !at_min
			&& !TMR_WE)
			|=> (count == 16'($past(count) - TPEC_STEP));
	endproperty
	a_x4_down: assert property (p_x4_down)
		else $error("Times-four reverse phase did not count down");

	property p_pin_latency;
		@(posedge CLK) disable iff (!RST_B)
		(running && !is_x4 && PHASE_B_PIN && $rose(PHASE_A_INPUT_PIN))
			##1 (running && !is_x4 && !TMR_WE && !at_max) [*2]
			|=> (count == 16'($past(count) + TPEC_STEP));
	endproperty
	a_pin_latency: assert property (p_pin_latency)
		else $error("Pin edge did not reach the counter in time");

	property p_running_source;
		@(posedge CLK) disable iff (!RST_B)
		(!a_edge && !b_edge && !TMR_WE) |=> (count == $past(count));
	endproperty
	a_running_source: assert property (p_running_source)
		else $error("Count moved without a pin edge");

	property p_start;
		@(posedge CLK) disable iff (!RST_B)
		(step_up && !at_max && !TMR_WE)
			|-> running ##1 (count == 16'($past(count) + TPEC_STEP));
	endproperty
	a_start: assert property (p_start)
		else $error("Counting not under start flag");

	property p_read_count;
		@(posedge CLK) disable iff (!RST_B)
		$changed(TMR_RDATA)
			|-> $past(TMR_WE) || $past(step_up) || $past(step_dn);
	endproperty
	a_read_count: assert property (p_read_count)
		else $error("Read port changed without a write or a count step");

	property p_reload_hold;
		@(posedge CLK) disable iff (!RST_B)
		!TMR_WE |=> (RELOAD_VALUE == $past(RELOAD_VALUE));
	endproperty
	a_reload_hold: assert property (p_reload_hold)
		else $error("Reload register changed without a write");

	property p_free_under;
		@(posedge CLK) disable iff (!RST_B)
		(step_dn && at_min && FREE_RUN)
			|=> (count == TPEC_CNT_MAX) && irq;
	endproperty
	a_free_under: assert property (p_free_under)
		else $error("Free-run underflow did not wrap to all ones");

	property p_normal_down;
		@(posedge CLK) disable iff (!RST_B)
		(running && !is_x4 && a_fall && b_lvl && !at_min && !TMR_WE)
			|=> (count == 16'($past(count) - TPEC_STEP));
	endproperty
	a_normal_down: assert property (p_normal_down)
		else $error("Normal mode falling edge did not count down");

	property p_normal_b_edge;
		@(posedge CLK) disable iff (!RST_B)
		(!is_x4 && b_edge && !a_edge && !TMR_WE)
			|=> (count == $past(count));
	endproperty
	a_normal_b_edge: assert property (p_normal_b_edge)
		else $error("Normal mode counted a pin B edge");

endmodule : tpec_counter

/* rtl/tpec_edge_if.sv */
// Synchronised pin levels and edge strobes between sampler and counter
`timescale 1ns/1ps
interface tpec_edge_if;
	logic [1:0] lvl;
	logic [1:0] rise;
	logic [1:0] fall;

	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface : tpec_edge_if

/* rtl/tpec_pkg.sv */
// Shared constants and types for the two-phase event counter
package tpec_pkg;

	localparam int          TPEC_CNT_W      = 16;
	localparam logic [15:0] TPEC_CNT_MAX    = 16'hffff;
	localparam logic [15:0] TPEC_CNT_MIN    = 16'h0000;
	localparam logic [15:0] TPEC_COUNT_RST  = 16'h0000;
	localparam logic [15:0] TPEC_RELOAD_RST = 16'h0000;
	localparam logic [15:0] TPEC_STEP       = 16'h0001;
	localparam int          TPEC_PIN_A      = 0;
	localparam int          TPEC_PIN_B      = 1;
	localparam int          TPEC_SYNC_LAT   = 3;

	typedef enum logic {
		TPEC_NORMAL,
		TPEC_X4
	} tpec_mode_t;

endpackage : tpec_pkg

/* rtl/tpec_sync.sv */
// Two-flop pin synchroniser with edge detection for one pulse input
`timescale 1ns/1ps
module tpec_sync #(
	parameter int IDX = 0
) (
	input  wire logic  clk,
	input  wire logic  rst_b,
	input  wire logic  pin,
	tpec_edge_if.src   edges
);
	import tpec_pkg::*;

	logic meta;
	logic sync;
	logic last;

	// Only the second flop reads the first
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= pin;
			sync <= meta;
			last <= sync;
		end
	end

	// Edges from the synchronised samples
	assign edges.lvl[IDX]  = sync;
	assign edges.rise[IDX] = sync & ~last;
	assign edges.fall[IDX] = ~sync & last;

endmodule : tpec_sync

/* verif/tb_two_phase_event_counter.sv */
// Self-checking bench for the two-phase event counter
`timescale 1ns/1ps
module tb_two_phase_event_counter;
	import tpec_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        start = 1'b0;
	logic        free_run = 1'b0;
	tpec_mode_t  mode = TPEC_NORMAL;
	logic        we = 1'b0;
	logic [15:0] wdata = 16'h0;
	logic [15:0] rdata;
	logic [15:0] reload;
	logic        irq;
	logic        pa;
	logic        pb;
	logic [15:0] irq_n = 16'h0;
	logic [15:0] n0;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	tpec_counter i_tpec_counter (
		.CLK(clk), .RST_B(rst_b), .PHASE_A_INPUT_PIN(pa), .PHASE_B_PIN(pb),
		.START_FLAG(start), .FREE_RUN(free_run), .MODE(mode), .TMR_WE(we),
		.TMR_WDATA(wdata), .TMR_RDATA(rdata), .RELOAD_VALUE(reload),
		.IRQ(irq)
	);
	tpec_enc_model i_tpec_enc_model (.clk(clk), .pin_a(pa), .pin_b(pb));

	always #25 clk = ~clk;

	always @(posedge clk) begin
		if (irq === 1'b1) begin
			irq_n <= irq_n + 16'h1;
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] v);
		@(posedge clk);
		#2 we = 1'b1;
		wdata = v;
		@(posedge clk);
		#2 we = 1'b0;
	endtask : wr

	task automatic run(input logic s);
		@(posedge clk);
		#2 start = s;
	endtask : run

	task automatic t_reset;
		chk(rdata, 16'h0);
		chk(reload, 16'h0);
		chk({15'h0, irq}, 16'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_write_stopped;
		wr(16'h1234);
		chk(rdata, 16'h1234);
		chk(reload, 16'h1234);
		$display("test write stopped done");
	endtask : t_write_stopped

	task automatic t_normal;
		mode = TPEC_NORMAL;
		wr(16'h0005);
		run(1'b1);
		i_tpec_enc_model.edges(4, 1'b1);
		chk(rdata, 16'h0006);
		i_tpec_enc_model.edges(4, 1'b0);
		chk(rdata, 16'h0005);
		run(1'b0);
		i_tpec_enc_model.edges(4, 1'b1);
		chk(rdata, 16'h0005);
		$display("test normal done");
	endtask : t_normal

	task automatic t_reload;
		mode = TPEC_X4;
		n0 = irq_n;
		wr(16'hfffe);
		run(1'b1);
		i_tpec_enc_model.edges(4, 1'b1);
		chk(rdata, 16'hfffe);
		chk(irq_n - n0, 16'h2);
		wr(16'h0001);
		chk(rdata, 16'hfffe);
		chk(reload, 16'h0001);
		i_tpec_enc_model.edges(2, 1'b1);
		chk(rdata, 16'h0001);
		i_tpec_enc_model.edges(2, 1'b0);
		chk(rdata, 16'h0001);
		chk(irq_n - n0, 16'h4);
		run(1'b0);
		$display("test reload done");
	endtask : t_reload

	task automatic t_free_run;
		free_run = 1'b1;
		wr(16'hffff);
		run(1'b1);
		i_tpec_enc_model.edges(1, 1'b1);
		chk(rdata, 16'h0000);
		i_tpec_enc_model.edges(1, 1'b0);
		chk(rdata, 16'hffff);
		run(1'b0);
		free_run = 1'b0;
		$display("test free run done");
	endtask : t_free_run

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (10) @(posedge clk);
		#2 rst_b = 1'b1;
		t_reset();
		t_write_stopped();
		t_normal();
		t_reload();
		t_free_run();
		report_and_stop();
	end
endmodule : tb_two_phase_event_counter

/* verif/tpec_enc_model.sv */
// Quadrature pulse source model driving both phase pins
`timescale 1ns/1ps
module tpec_enc_model (
	input  wire logic clk,
	output logic      pin_a,
	output logic      pin_b
);
	logic [1:0] q = 2'h0;

	// Gray sequence 00,01,11,10 counts up; reverse counts down
	assign pin_a = q[1];
	assign pin_b = q[1] ^ q[0];

	// One edge per step, each level held seven cycles
	task automatic edges(input int n, input bit up);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#2 q = up ? q + 2'h1 : q - 2'h1;
			repeat (6) @(posedge clk);
		end
		// Return off the clock edge so callers sample settled outputs
		#2;
	endtask : edges
endmodule : tpec_enc_model
